// ---- pkg/apx_defines.svh ----
`ifndef APX_DEFINES_SVH
`define APX_DEFINES_SVH

// Fixed command latencies in device clock cycles
`define APX_CYC_NOP      16'd4
`define APX_CYC_SINGLE_FIXED_ADD     16'd17
`define APX_CYC_SSUB     16'd30
`define APX_CYC_DOUBLE_FIXED_ADD     16'd21
`define APX_CYC_DSUB     16'd38
`define APX_CYC_DOUBLE_FIXED_DIVIDE     16'd208
// Scaling step that follows the logarithm phase
`define APX_CYC_LOG_MUL  16'd176
`define APX_CYC_PWR_MUL  16'd198

// Command byte encodings
`define APX_OP_NOP       8'h00
`define APX_OP_SINGLE_FIXED_ADD      8'h6c
`define APX_OP_SSUB      8'h6d
`define APX_OP_DOUBLE_FIXED_ADD      8'h2c
`define APX_OP_DSUB      8'h2d
`define APX_OP_DOUBLE_FIXED_DIVIDE      8'h2f
`define APX_OP_LOG       8'h08
`define APX_OP_LN        8'h09
`define APX_OP_EXP       8'h0a
`define APX_OP_PWR       8'h0b

// Status byte layout
`define APX_ST_BUSY      7
`define APX_ST_SIGN      6
`define APX_ST_ZERO      5
`define APX_ST_ERR_HI    4
`define APX_ST_ERR_LO    1
`define APX_ST_CARRY     0
`define APX_ST_RST       7'h00

// Error codes
`define APX_ERR_NONE     4'h0
`define APX_ERR_DIVZ     4'h8
`define APX_ERR_NEG      4'h4

// Base-ten conversion factor 0.43429448 in unsigned Q0.32
`define APX_LOG10_K      32'h6f2dec55

`endif

// ---- pkg/apx_exec_if.sv ----
`default_nettype none
interface apx_exec_if;
	logic       cmd_take;
	logic [7:0] cmd_byte;
	logic       data_take;
	logic [7:0] data_byte;
	logic       data_pop;
	logic [7:0] rd_byte;
	logic       busy;
	logic [7:0] status;

	// Pin side
	modport pins (
		output cmd_take, cmd_byte, data_take, data_byte, data_pop,
		input  rd_byte, busy, status
	);

	// Execution core side
	modport core (
		input  cmd_take, cmd_byte, data_take, data_byte, data_pop,
		output rd_byte, busy, status
	);
endinterface
`default_nettype wire

// ---- pkg/apx_pkg.sv ----
`default_nettype none
package apx_pkg;

	// Sequencer phase
	typedef enum logic [1:0] {
		APX_PH_IDLE,
		APX_PH_FIRST,
		APX_PH_MUL,
		APX_PH_LAST
	} apx_phase_t;

	// Decoded command class
	typedef enum logic [3:0] {
		APX_C_NOP,
		APX_C_SINGLE_FIXED_ADD,
		APX_C_SSUB,
		APX_C_DOUBLE_FIXED_ADD,
		APX_C_DSUB,
		APX_C_DOUBLE_FIXED_DIVIDE,
		APX_C_LN,
		APX_C_LOG,
		APX_C_EXP,
		APX_C_PWR
	} apx_cmd_t;

endpackage
`default_nettype wire

// ---- rtl/apx_bus_port.sv ----
`default_nettype none
module apx_bus_port (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       cs_b,
	input  wire logic       command_data_select,
	input  wire logic       rd_b,
	input  wire logic       wr_b,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_b,
	output logic            ready,
	apx_exec_if.pins        ex
);
	logic st_rd;
	logic dt_rd;
	logic cm_wr;
	logic dt_wr;
	logic any_acc;
	logic take;
	logic served_q;

	// Strobe decode
	assign st_rd   = !cs_b && command_data_select && !rd_b;
	assign dt_rd   = !cs_b && !command_data_select && !rd_b;
	assign cm_wr   = !cs_b && command_data_select && !wr_b;
	assign dt_wr   = !cs_b && !command_data_select && !wr_b;
	assign any_acc = st_rd || dt_rd || cm_wr || dt_wr;
	// Status goes at once; other accesses wait for the end of execution
	assign take    = any_acc && !served_q && (st_rd || !ex.busy);

	assign ex.cmd_take  = take && cm_wr;
	assign ex.cmd_byte  = data_in;
	assign ex.data_take = take && dt_wr;
	assign ex.data_byte = data_in;
	assign ex.data_pop  = take && dt_rd;

	// One service per strobe
	always_ff @(posedge clk) begin
		if (!rst_b)
			served_q <= 1'b0;
		else if (!any_acc)
			served_q <= 1'b0;
		else if (take)
			served_q <= 1'b1;
	end

	// Ready low from strobe until serviced
	always_ff @(posedge clk) begin
		if (!rst_b)
			ready <= 1'b1;
		else
			ready <= !(any_acc && !served_q);
	end

	// Output latch, loaded once per read so the byte never mixes
	always_ff @(posedge clk) begin
		if (!rst_b)
			data_out <= 8'h00;
		else if (take && st_rd)
			data_out <= ex.status;
		else if (take && dt_rd)
			data_out <= ex.rd_byte;
	end

	// Drive the bus while a serviced read is held
	always_ff @(posedge clk) begin
		if (!rst_b)
			data_oe_b <= 1'b1;
		else
			data_oe_b <= !((st_rd || dt_rd) && (served_q || take));
	end
endmodule
`default_nettype wire

// ---- rtl/apx_exec.sv ----
`include "apx_defines.svh"
`default_nettype none
module apx_exec
	import apx_pkg::*;
#(
	parameter int CW          = 16,
	parameter int LN_MIN_CYC  = 4298,
	parameter int LN_MAX_CYC  = 6956,
	parameter int EXP_MIN_CYC = 3794,
	parameter int EXP_MAX_CYC = 4878
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       cs_b,
	input  wire logic       command_data_select,
	input  wire logic       rd_b,
	input  wire logic       wr_b,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_b,
	output logic            ready
);
	apx_exec_if ex ();

	apx_cmd_t      cmd_q;
	apx_cmd_t      cmd_d;
	apx_phase_t    phase;
	logic [CW-1:0] len1_d;
	logic [CW-1:0] len2_d;
	logic [CW-1:0] len3_d;
	logic          start;
	logic          busy;
	logic          phase_end;
	logic          done;
	logic [63:0]   opnd_q;
	logic [31:0]   acc_q;
	logic [31:0]   acc_d;
	logic [31:0]   fin_val;
	logic [31:0]   y_q;
	logic [31:0]   res_q;
	logic          carry_q;
	logic          carry_d;
	logic [3:0]    err_q;
	logic [3:0]    err_d;
	logic [6:0]    stat_q;
	logic [16:0]   s_sum;
	logic [32:0]   d_sum;
	logic [64:0]   log_prod;
	logic [63:0]   pwr_prod;

	// Latency span bounds in cycles
	localparam logic [CW-1:0] LN_LO  = CW'(LN_MIN_CYC);
	localparam logic [CW-1:0] LN_HI  = CW'(LN_MAX_CYC);
	localparam logic [CW-1:0] EXP_LO = CW'(EXP_MIN_CYC);
	localparam logic [CW-1:0] EXP_HI = CW'(EXP_MAX_CYC);

	// Pin handling and status snapshot
	apx_bus_port u_port (
		.clk                 (clk),
		.rst_b               (rst_b),
		.cs_b                (cs_b),
		.command_data_select (command_data_select),
		.rd_b                (rd_b),
		.wr_b                (wr_b),
		.data_in             (data_in),
		.data_out            (data_out),
		.data_oe_b           (data_oe_b),
		.ready               (ready),
		.ex                  (ex.pins)
	);

	// Cycle sequencer
	apx_seq #(
		.CW (CW)
	) u_seq (
		.clk       (clk),
		.rst_b     (rst_b),
		.start     (start),
		.len_first (len1_d),
		.len_mul   (len2_d),
		.len_last  (len3_d),
		.busy      (busy),
		.phase_end (phase_end),
		.done      (done),
		.phase     (phase)
	);

	assign start = ex.cmd_take && !busy;

	// Pick a length inside [lo, hi) from an operand byte
	function automatic logic [CW-1:0] span_pick(
		input logic [CW-1:0] lo,
		input logic [CW-1:0] hi,
		input logic [7:0]    sel
	);
		logic [CW+7:0] prod;
		prod      = (CW+8)'(hi - lo) * (CW+8)'(sel);
		span_pick = lo + prod[CW+7:8];
	endfunction

	// Command decode and phase lengths
	always_comb begin
		cmd_d  = APX_C_NOP;
		len1_d = `APX_CYC_NOP;
		len2_d = '0;
		len3_d = '0;
		case (ex.cmd_byte)
			`APX_OP_SINGLE_FIXED_ADD: begin
				cmd_d  = APX_C_SINGLE_FIXED_ADD;
				len1_d = `APX_CYC_SINGLE_FIXED_ADD;
			end
			`APX_OP_SSUB: begin
				cmd_d  = APX_C_SSUB;
				len1_d = `APX_CYC_SSUB;
			end
			`APX_OP_DOUBLE_FIXED_ADD: begin
				cmd_d  = APX_C_DOUBLE_FIXED_ADD;
				len1_d = `APX_CYC_DOUBLE_FIXED_ADD;
			end
			`APX_OP_DSUB: begin
				cmd_d  = APX_C_DSUB;
				len1_d = `APX_CYC_DSUB;
			end
			`APX_OP_DOUBLE_FIXED_DIVIDE: begin
				cmd_d  = APX_C_DOUBLE_FIXED_DIVIDE;
				len1_d = `APX_CYC_DOUBLE_FIXED_DIVIDE;
			end
			`APX_OP_LN: begin
				cmd_d  = APX_C_LN;
				len1_d = span_pick(LN_LO, LN_HI, opnd_q[7:0]);
			end
			`APX_OP_LOG: begin
				cmd_d  = APX_C_LOG;
				len1_d = span_pick(LN_LO, LN_HI, opnd_q[7:0]);
				len2_d = `APX_CYC_LOG_MUL;
			end
			`APX_OP_EXP: begin
				cmd_d  = APX_C_EXP;
				len1_d = span_pick(EXP_LO, EXP_HI, opnd_q[7:0]);
			end
			`APX_OP_PWR: begin
				cmd_d  = APX_C_PWR;
				len1_d = span_pick(LN_LO, LN_HI, opnd_q[39:32]);
				len2_d = `APX_CYC_PWR_MUL;
				len3_d = span_pick(EXP_LO, EXP_HI, opnd_q[7:0]);
			end
			default: begin
				cmd_d  = APX_C_NOP;
				len1_d = `APX_CYC_NOP;
			end
		endcase
	end

	// Operand entry: newest byte on top
	always_ff @(posedge clk) begin
		if (!rst_b)
			opnd_q <= 64'h0;
		else if (ex.data_take)
			opnd_q <= {opnd_q[55:0], ex.data_byte};
	end

	// Integer arithmetic on the operand words
	assign s_sum = (cmd_d == APX_C_SSUB) ? ({1'b0, opnd_q[31:16]} - {1'b0, opnd_q[15:0]})
		: ({1'b0, opnd_q[31:16]} + {1'b0, opnd_q[15:0]});
	assign d_sum = (cmd_d == APX_C_DSUB) ? ({1'b0, opnd_q[63:32]} - {1'b0, opnd_q[31:0]})
		: ({1'b0, opnd_q[63:32]} + {1'b0, opnd_q[31:0]});

	// Result, carry and error prepared at acceptance
	always_comb begin
		acc_d   = opnd_q[31:0];
		carry_d = 1'b0;
		err_d   = `APX_ERR_NONE;
		case (cmd_d)
			APX_C_SINGLE_FIXED_ADD, APX_C_SSUB: begin
				acc_d   = {16'h0000, s_sum[15:0]};
				carry_d = s_sum[16];
			end
			APX_C_DOUBLE_FIXED_ADD, APX_C_DSUB: begin
				acc_d   = d_sum[31:0];
				carry_d = d_sum[32];
			end
			APX_C_DOUBLE_FIXED_DIVIDE: begin
				if (opnd_q[31:0] == 32'h0) begin
					acc_d = 32'h0;
					err_d = `APX_ERR_DIVZ;
				end else
					acc_d = opnd_q[63:32] / opnd_q[31:0];
			end
			APX_C_LN, APX_C_LOG: begin
				if ($signed(opnd_q[31:0]) <= 0)
					err_d = `APX_ERR_NEG;
			end
			APX_C_PWR: begin
				acc_d = opnd_q[63:32];
				if ($signed(opnd_q[63:32]) <= 0)
					err_d = `APX_ERR_NEG;
			end
			default: begin
				acc_d = opnd_q[31:0];
			end
		endcase
	end

	// Scaling products, Q0.32 constant and Q16.16 exponent
	assign log_prod = $signed({{33{acc_q[31]}}, acc_q}) * $signed({33'h0, `APX_LOG10_K});
	assign pwr_prod = $signed({{32{acc_q[31]}}, acc_q}) * $signed({{32{y_q[31]}}, y_q});

	// Value that stands when the command ends, scaling step included
	always_comb begin
		fin_val = acc_q;
		if (phase_end && phase == APX_PH_MUL) begin
			if (cmd_q == APX_C_LOG)
				fin_val = log_prod[63:32];
			else
				fin_val = pwr_prod[47:16];
		end
	end

	// Command register and exponent capture
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmd_q   <= APX_C_NOP;
			y_q     <= 32'h0;
			carry_q <= 1'b0;
			err_q   <= `APX_ERR_NONE;
		end else if (start) begin
			cmd_q   <= cmd_d;
			y_q     <= opnd_q[31:0];
			carry_q <= carry_d;
			err_q   <= err_d;
		end
	end

	// Working value walks through the phases
	always_ff @(posedge clk) begin
		if (!rst_b)
			acc_q <= 32'h0;
		else if (start)
			acc_q <= acc_d;
		else if (phase_end && phase == APX_PH_MUL) begin
			if (cmd_q == APX_C_LOG)
				acc_q <= log_prod[63:32];
			else
				acc_q <= pwr_prod[47:16];
		end
	end

	// Result popped by data reads, rotating like the stack
	// Loaded in the last busy cycle, so a read after busy falls sees it
	always_ff @(posedge clk) begin
		if (!rst_b)
			res_q <= 32'h0;
		else if (done)
			res_q <= fin_val;
		else if (ex.data_pop)
			res_q <= {res_q[7:0], res_q[31:8]};
	end

	// Finished status fields, held unchanged while busy
	// Written on the edge that clears busy: a later load would let a read
	// in the first idle cycle see busy low beside stale fields
	always_ff @(posedge clk) begin
		if (!rst_b)
			stat_q <= `APX_ST_RST;
		else if (done) begin
			stat_q[`APX_ST_SIGN]                   <= fin_val[31];
			stat_q[`APX_ST_ZERO]                   <= (fin_val == 32'h0);
			stat_q[`APX_ST_ERR_HI:`APX_ST_ERR_LO]  <= err_q;
			stat_q[`APX_ST_CARRY]                  <= carry_q;
		end
	end

	// Busy and fields change on the same edge, so a snapshot is whole
	assign ex.status  = {busy, stat_q};
	assign ex.busy    = busy;
	assign ex.rd_byte = res_q[7:0];
endmodule
`default_nettype wire

// ---- rtl/apx_seq.sv ----
`default_nettype none
module apx_seq
	import apx_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          start,
	input  wire logic [CW-1:0] len_first,
	input  wire logic [CW-1:0] len_mul,
	input  wire logic [CW-1:0] len_last,
	output logic               busy,
	output logic               phase_end,
	output logic               done,
	output apx_phase_t         phase
);
	apx_phase_t    phase_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] mul_q;
	logic [CW-1:0] last_q;

	assign phase     = phase_q;
	assign busy      = (phase_q != APX_PH_IDLE);
	assign phase_end = busy && (cnt_q == '0);

	// Phase walk: first, optional scaling, optional final step
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase_q <= APX_PH_IDLE;
			cnt_q   <= '0;
			mul_q   <= '0;
			last_q  <= '0;
		end else if (start && !busy) begin
			phase_q <= APX_PH_FIRST;
			cnt_q   <= len_first - 1'b1;
			mul_q   <= len_mul;
			last_q  <= len_last;
		end else if (phase_end) begin
			case (phase_q)
				APX_PH_FIRST: begin
					if (mul_q != '0) begin
						phase_q <= APX_PH_MUL;
						cnt_q   <= mul_q - 1'b1;
					end else if (last_q != '0) begin
						phase_q <= APX_PH_LAST;
						cnt_q   <= last_q - 1'b1;
					end else
						phase_q <= APX_PH_IDLE;
				end
				APX_PH_MUL: begin
					if (last_q != '0) begin
						phase_q <= APX_PH_LAST;
						cnt_q   <= last_q - 1'b1;
					end else
						phase_q <= APX_PH_IDLE;
				end
				default: phase_q <= APX_PH_IDLE;
			endcase
		end else if (busy)
			cnt_q <= cnt_q - 1'b1;
	end

	// Last busy cycle, so results land on the same edge that clears busy
	assign done = phase_end && ((phase_q == APX_PH_LAST) ||
		(phase_q == APX_PH_MUL && last_q == '0) ||
		(phase_q == APX_PH_FIRST && mul_q == '0 && last_q == '0));
endmodule
`default_nettype wire

// ---- verif/apx_exec_properties.sv ----
`default_nettype none
module apx_exec_properties (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       cs_b,
	input wire logic       command_data_select,
	input wire logic       rd_b,
	input wire logic       wr_b,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe_b,
	input wire logic       ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_act;
	logic wr_act;
	logic any_act;
	// Decoded host strobes
	assign rd_act = !cs_b && !rd_b;
	assign wr_act = !cs_b && !wr_b;
	assign any_act = rd_act || wr_act;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	a_status_no_wait: assert property ($rose(rd_act) && command_data_select |=> !ready && !data_oe_b ##1 ready)
		else $error("status read was not answered in two cycles");
	a_oe_release: assert property ($fell(rd_act) |=> data_oe_b)
		else $error("bus still driven after read strobe release");
	a_oe_needs_read: assert property (!data_oe_b |-> $past(rd_act))
		else $error("bus driven without a read");
	a_out_held: assert property (!data_oe_b && !$past(data_oe_b) |-> $stable(data_out))
		else $error("read byte changed while driven");
	a_write_ack: assert property ($rose(wr_act) |=> !ready)
		else $error("write strobe not acknowledged by ready low");
	a_ready_idle: assert property (!any_act ##1 !any_act |-> ready)
		else $error("ready low with no access");
	a_ready_cause: assert property (!ready |-> $past(any_act))
		else $error("ready dropped without a strobe");
	a_stall_bound: assert property (wr_act && !ready |-> ##[1:1000] ready)
		else $error("stalled write never released");
	a_write_no_oe: assert property (wr_act |=> data_oe_b)
		else $error("bus driven during a write");
endmodule
bind apx_exec apx_exec_properties u_props (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
	.command_data_select(command_data_select), .rd_b(rd_b), .wr_b(wr_b), .data_in(data_in),
	.data_out(data_out), .data_oe_b(data_oe_b), .ready(ready));
`default_nettype wire

// ---- verif/apx_exec_tb.sv ----
`include "apx_defines.svh"
`default_nettype none
module apx_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LMIN = 20;
	localparam int LMAX = 40;
	localparam int EMIN = 10;
	localparam int EMAX = 30;
	logic        clk;
	logic        rst_b;
	logic        cs_b;
	logic        cds;
	logic        rd_b;
	logic        wr_b;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic        data_oe_b;
	logic        ready;
	logic        hung;
	logic [31:0] cyc_q;
	logic        oe_q;
	logic [15:0] exp_q[$];
	logic [15:0] note;
	logic [31:0] t0;
	logic [31:0] t1;
	logic [7:0]  ops[11];
	int          miscompares;
	int          n_compared;
	int          seed;
	apx_exec #(.LN_MIN_CYC(LMIN), .LN_MAX_CYC(LMAX), .EXP_MIN_CYC(EMIN), .EXP_MAX_CYC(EMAX)) uut (
		.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .command_data_select(cds), .rd_b(rd_b), .wr_b(wr_b),
		.data_in(data_in), .data_out(data_out), .data_oe_b(data_oe_b), .ready(ready));
	apx_host_model u_host (.clk(clk), .ready(ready), .cs_b(cs_b), .command_data_select(cds), .rd_b(rd_b),
		.wr_b(wr_b), .data_in(data_in), .hung(hung), .cyc_q(cyc_q));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (exp_q.size() != 0) miscompares++;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Read results are compared against the oldest note as the bus is driven
	always @(posedge clk) begin
		if (rst_b === 1'b1 && data_oe_b === 1'b0 && oe_q === 1'b1) begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
			check(data_out & note[15:8], note[7:0]);
		end
		oe_q <= data_oe_b;
	end
	task automatic acc(input logic cd, input logic rd, input logic [7:0] b, output logic [31:0] t);
		u_host.access(cd, rd, b, t);
		if (hung) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic wait_to(input logic [31:0] e);
		while (cyc_q < e) @(posedge clk);
	endtask
	task automatic rd_st(input logic [7:0] m, input logic [7:0] e);
		logic [31:0] t;
		exp_q.push_back({m, e});
		acc(1'b1, 1'b1, 8'h00, t);
	endtask
	function automatic int ln_c(input logic [7:0] b);
		return LMIN + (((LMAX - LMIN) * b) >> 8);
	endfunction
	function automatic int ex_c(input logic [7:0] b);
		return EMIN + (((EMAX - EMIN) * b) >> 8);
	endfunction
	// Expected latency in device cycles
	function automatic int lat(input logic [7:0] op, input logic [63:0] o);
		case (op)
			`APX_OP_SINGLE_FIXED_ADD: return 17;
			`APX_OP_SSUB: return 30;
			`APX_OP_DOUBLE_FIXED_ADD: return 21;
			`APX_OP_DSUB: return 38;
			`APX_OP_DOUBLE_FIXED_DIVIDE: return 208;
			`APX_OP_LN: return ln_c(o[7:0]);
			`APX_OP_LOG: return ln_c(o[7:0]) + 176;
			`APX_OP_EXP: return ex_c(o[7:0]);
			`APX_OP_PWR: return ln_c(o[39:32]) + 198 + ex_c(o[7:0]);
			default: return 4;
		endcase
	endfunction
	// Load operand, issue command, then probe busy just before (only when the latency is 8 or more) and after the count ends
	task automatic run_cmd(input logic [7:0] op, input logic [63:0] o);
		logic [31:0] t;
		int          n;
		for (int i = 7; i >= 0; i--) acc(1'b0, 1'b0, o[i*8 +: 8], t);
		acc(1'b1, 1'b0, op, t);
		n = lat(op, o);
		if (n >= 8) begin
			wait_to(t + n - 3);
			rd_st(8'h80, 8'h80);
		end
		wait_to(t + n - 1);
		rd_st(8'h80, 8'h00);
	endtask
	initial begin
		rst_b = 1'b0;
		oe_q = 1'b1;
		miscompares = 0;
		n_compared = 0;
		seed = 14;
		ops = '{`APX_OP_NOP, `APX_OP_SINGLE_FIXED_ADD, `APX_OP_SSUB, `APX_OP_DOUBLE_FIXED_ADD, `APX_OP_DSUB, `APX_OP_DOUBLE_FIXED_DIVIDE,
			`APX_OP_LN, `APX_OP_LOG, `APX_OP_EXP, `APX_OP_PWR, 8'hff};
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check({7'h0, ready}, 8'h01);
		check({7'h0, data_oe_b}, 8'h01);
		rd_st(8'hff, 8'h00);
		$display("Test reset state done");
		for (int i = 0; i < 11; i++) run_cmd(ops[i], {$random(seed), $random(seed)});
		$display("Test command latencies done");
		run_cmd(`APX_OP_DOUBLE_FIXED_DIVIDE, 64'h0);
		rd_st(8'h9e, 8'h10);
		run_cmd(`APX_OP_NOP, 64'h0);
		acc(1'b1, 1'b0, `APX_OP_DOUBLE_FIXED_DIVIDE, t0);
		wait_to(t0 + 207);
		rd_st(8'h9e, 8'h10);
		$display("Test divide by zero done");
		run_cmd(`APX_OP_SINGLE_FIXED_ADD, 64'h0000_0000_1234_0f0f);
		exp_q.push_back(16'hff43);
		acc(1'b0, 1'b1, 8'h00, t0);
		exp_q.push_back(16'hff21);
		acc(1'b0, 1'b1, 8'h00, t0);
		$display("Test add result done");
		acc(1'b1, 1'b0, `APX_OP_DOUBLE_FIXED_DIVIDE, t0);
		acc(1'b1, 1'b0, `APX_OP_NOP, t1);
		check({7'h0, (t1 - t0 == 208) || (t1 - t0 == 209)}, 8'h01);
		wait_to(t1 + 3);
		rd_st(8'h80, 8'h00);
		$display("Test stalled command done");
		acc(1'b1, 1'b0, `APX_OP_DOUBLE_FIXED_DIVIDE, t0);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_st(8'hff, 8'h00);
		$display("Test mid-run reset done");
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- verif/apx_host_model.sv ----
`default_nettype none
module apx_host_model (
	input  wire logic        clk,
	input  wire logic        ready,
	output logic             cs_b,
	output logic             command_data_select,
	output logic             rd_b,
	output logic             wr_b,
	output logic [7:0]       data_in,
	output logic             hung,
	output logic [31:0]      cyc_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] dat_q;
	logic [7:0] idle_q;
	// Idle bus levels at time zero
	initial begin
		cs_b = 1'b1;
		command_data_select = 1'b1;
		rd_b = 1'b1;
		wr_b = 1'b1;
		dat_q = 8'h00;
		idle_q = 8'h5a;
		hung = 1'b0;
		cyc_q = 32'h0;
	end
	// Edge counter and a toggling pattern on the released bus
	always @(posedge clk) begin
		cyc_q <= cyc_q + 32'h1;
		idle_q <= ~idle_q;
	end
	assign data_in = wr_b ? idle_q : dat_q;
	// One access; take returns the edge count at which the device accepted it
	task automatic access(input logic cd, input logic rd, input logic [7:0] b, output logic [31:0] take);
		logic seen_low;
		int   n;
		seen_low = 1'b0;
		n = 0;
		@(posedge clk);
		cs_b <= 1'b0;
		command_data_select <= cd;
		rd_b <= !rd;
		wr_b <= rd;
		dat_q <= b;
		// Hold all bus signals until ready returns high
		do begin
			@(posedge clk);
			seen_low = seen_low | !ready;
			n++;
		end while (!(seen_low && ready === 1'b1) && n < 2000);
		if (n >= 2000) hung = 1'b1;
		take = cyc_q - 32'd2;
		cs_b <= 1'b1;
		rd_b <= 1'b1;
		wr_b <= 1'b1;
	endtask
endmodule
`default_nettype wire
